// ==== bench/brf_cpu_model.sv ====
// execution-core model: bank select, named register and data memory requests
`timescale 1ns/10ps
`default_nettype none
module brf_cpu_model
(
    // clock
    input wire logic clk_sys,
    // bank select and named register
    output logic bankSelStrobe,
    output logic [1:0] bankSelValue,
    output logic [2:0] regIdx,
    output logic regPair,
    output logic regWrEn,
    output logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    // data memory
    output logic memReq,
    output logic memWrite,
    output logic [1:0] memWidth,
    output logic [15:0] memAddr,
    output logic [2:0] memBitIdx,
    output logic [15:0] memWrData,
    input wire logic memAck,
    input wire logic memErr,
    input wire logic [15:0] memRdData
);
    initial
    begin
        {bankSelStrobe, bankSelValue, regIdx, regPair, regWrEn, regWrData} = '0;
        {memReq, memWrite, memWidth, memAddr, memBitIdx, memWrData} = '0;
    end

    task automatic sel_bank(input logic [1:0] b);
        @(posedge clk_sys);
        #1;
        bankSelStrobe = 1'b1;
        bankSelValue = b;
        @(posedge clk_sys);
        #1;
        bankSelStrobe = 1'b0;
        bankSelValue = ~b;
    endtask

    task automatic put_reg(input logic [2:0] i, input logic p, input logic [15:0] d);
        @(posedge clk_sys);
        #1;
        {regIdx, regPair, regWrEn, regWrData} = {i, p, 1'b1, d};
        @(posedge clk_sys);
        #1;
        regWrEn = 1'b0;
        regWrData = ~d;
    endtask

    // readback is registered, so inputs are held over two edges
    task automatic look_reg(input logic [2:0] i, input logic p, output logic [15:0] rd);
        @(posedge clk_sys);
        #1;
        {regIdx, regPair} = {i, p};
        repeat (2) @(posedge clk_sys);
        #1;
        rd = regRdData;
    endtask

    // odd word or unassigned addresses only when a scenario passes them on purpose
    task automatic mem(input logic wr, input logic [1:0] w, input logic [15:0] a,
                       input logic [2:0] b, input logic [15:0] d,
                       output logic ack, output logic err, output logic [15:0] rd);
        @(posedge clk_sys);
        #1;
        {memReq, memWrite, memWidth, memAddr, memBitIdx, memWrData} = {1'b1, wr, w, a, b, d};
        @(posedge clk_sys);
        #1;
        // released lines carry junk so a stale value is never mistaken for a request
        {memReq, memWrite, memAddr, memWrData} = {1'b0, 1'b0, ~a, ~d};
        {ack, err, rd} = {memAck, memErr, memRdData};
    endtask
endmodule
`default_nettype wire

// ==== bench/brf_regfile_test.sv ====
// self-checking bench for the banked register file and peripheral decode
`timescale 1ns/10ps
`default_nettype none
module brf_regfile_test;
    // design nets
    logic clk_sys, nrst, bankSelStrobe, regPair, regWrEn, memReq, memWrite;
    logic memAck, memErr, memRamSel, convResultLoad, rxDataLoad, serialTxLoad, ack, err;
    logic [1:0] bankSelValue, pswBankField, memWidth;
    logic [2:0] regIdx, memBitIdx;
    logic [7:0] portTwoPin, rxDataIn, portDataZero, portDirZero, serialTxData;
    logic [15:0] regWrData, regRdData, memAddr, memWrData, memRdData, convResultIn, rd;
    logic [15:0] timerCountIn, captureCompareA, captureCompareB;
    int mismatches;
    int n_checks;
    localparam logic [3:0] RD_T = 4'h0, RD_B = 4'h1, RD_W = 4'h2, WR_T = 4'h8, WR_B = 4'h9;
    localparam logic [3:0] WR_W = 4'hA;

    brf_regfile i_dut (
        .clk_sys, .nrst, .bankSelStrobe, .bankSelValue, .pswBankField, .regIdx, .regPair,
        .regWrEn, .regWrData, .regRdData, .memReq, .memWrite, .memWidth, .memAddr,
        .memBitIdx, .memWrData, .memAck, .memErr, .memRdData, .memRamSel, .portTwoPin,
        .convResultIn, .convResultLoad, .rxDataIn, .rxDataLoad, .timerCountIn,
        .portDataZero, .portDirZero, .serialTxData, .serialTxLoad, .captureCompareA,
        .captureCompareB
    );
    brf_cpu_model i_cpu (
        .clk_sys, .bankSelStrobe, .bankSelValue, .regIdx, .regPair, .regWrEn, .regWrData,
        .regRdData, .memReq, .memWrite, .memWidth, .memAddr, .memBitIdx, .memWrData,
        .memAck, .memErr, .memRdData
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // op: bit 3 write, bits 1:0 width; v is write data or expected read
    task automatic go(input logic [3:0] op, input logic [15:0] a, input logic [2:0] b,
                      input logic [15:0] v, input logic e);
        logic [15:0] m;
        m = (op[1:0] == 2'h2) ? 16'hFFFF : (op[1:0] == 2'h1) ? 16'h00FF : 16'h0001;
        i_cpu.mem(op[3], op[1:0], a, b, v, ack, err, rd);
        chk({14'h0, err, ack}, {14'h0, e, ~e});
        if (!op[3] && !e)
            chk(rd & m, v);
    endtask

    task automatic t_reset();
        chk({14'h0, pswBankField}, 16'h0000);
        chk({portDirZero, serialTxData}, 16'hFFFF);
        go(RD_B, 16'hFF00, 3'h0, 16'h0000, 1'b0);
        go(RD_B, 16'hFF21, 3'h0, 16'h00FF, 1'b0);
        go(RD_B, 16'hFF0A, 3'h0, 16'h00FF, 1'b0);
        go(RD_W, 16'hFF14, 3'h0, 16'h0000, 1'b0);
    endtask

    task automatic t_banks();
        logic [15:0] a;
        for (int b = 0; b < 4; b++)
        begin
            i_cpu.sel_bank(2'(b));
            chk({14'h0, pswBankField}, 16'(b));
            i_cpu.put_reg(3'(b + 3), 1'b0, 16'(8'h40 + b));
            a = 16'hFEE0 + 16'((3 - b) * 8 + b + 3);
            go(RD_B, a, 3'h0, 16'(8'h40 + b), 1'b0);
        end
        go(WR_W, 16'hFEE4, 3'h0, 16'hBEEF, 1'b0);
        i_cpu.look_reg(3'h2, 1'b1, rd);
        chk(rd, 16'hBEEF);
        i_cpu.put_reg(3'h1, 1'b1, 16'h1234);
        go(RD_W, 16'hFEE2, 3'h0, 16'h1234, 1'b0);
        chk({14'h0, pswBankField}, 16'h0003);
    endtask

    task automatic t_refuse();
        logic [19:0] bad [10];
        bad = '{{4'h2, 16'hFF00}, {4'h9, 16'hFF12}, {4'h0, 16'hFF0A}, {4'hA, 16'hFF10},
                {4'h9, 16'hFF02}, {4'h1, 16'hFF04}, {4'h3, 16'hFF00}, {4'hA, 16'hFF13},
                {4'h2, 16'hFF0A}, {4'h9, 16'hFF0A}};
        go(WR_W, 16'hFF12, 3'h0, 16'h1234, 1'b0);
        for (int i = 0; i < 10; i++)
        begin
            go(bad[i][19:16], bad[i][15:0], 3'h0, 16'hC3C3, 1'b1);
        end
        go(RD_W, 16'hFF12, 3'h0, 16'h1234, 1'b0);
        chk(captureCompareA, 16'h1234);
        // plain RAM: select raised while the request stands, no answer after
        fork
            i_cpu.mem(1'b0, 2'h1, 16'hFE00, 3'h0, 16'h0000, ack, err, rd);
            begin
                @(posedge clk_sys);
                #2;
                chk({15'h0, memRamSel}, 16'h0001);
            end
        join
        chk({14'h0, err, ack}, 16'h0000);
    endtask

    task automatic t_periph();
        go(WR_W, 16'hFF14, 3'h0, 16'h5678, 1'b0);
        chk(captureCompareB, 16'h5678);
        go(WR_B, 16'hFF0B, 3'h0, 16'h005A, 1'b0);
        chk({7'h0, serialTxLoad, serialTxData}, 16'h015A);
        go(WR_B, 16'hFF00, 3'h0, 16'h0096, 1'b0);
        go(WR_T, 16'hFF20, 3'h3, 16'h0000, 1'b0);
        chk({portDataZero, portDirZero}, 16'h96F7);
        go(RD_T, 16'hFF20, 3'h2, 16'h0001, 1'b0);
        {convResultIn, rxDataIn, timerCountIn, portTwoPin} = {16'hABCD, 8'h3C, 16'h1357, 8'hA5};
        // result read in the cycle right after its load; pin read last, behind the synchroniser
        fork
            begin
                {convResultLoad, rxDataLoad} = 2'b11;
                @(posedge clk_sys);
                #1;
                {convResultLoad, rxDataLoad} = 2'b00;
            end
            go(RD_W, 16'hFF08, 3'h0, 16'hABCD, 1'b0);
        join
        go(RD_B, 16'hFF0A, 3'h0, 16'h003C, 1'b0);
        go(RD_W, 16'hFF10, 3'h0, 16'h1357, 1'b0);
        go(RD_B, 16'hFF02, 3'h0, 16'h00A5, 1'b0);
    endtask

    initial
    begin
        mismatches = 0;
        n_checks = 0;
        nrst = 1'b0;
        {portTwoPin, rxDataIn, convResultLoad, rxDataLoad} = '0;
        {convResultIn, timerCountIn} = '0;
        repeat (6) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        t_reset();
        t_banks();
        t_refuse();
        t_periph();
        close_out();
    end

    // the sequence needs about 90 cycles; over thirtyfold margin
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire

// ==== hw/brf_pkg.sv ====
// constants, access table and reset values for the banked register file and peripheral decode
// Function
// - general registers live at FEE0H..FEFFH as four banks of eight bytes
// - bank 0 at FEF8H, 1 at FEF0H, 2 at FEE8H, 3 at FEE0H
// - bytes pair into four 16-bit registers, low byte at even register
// - only the bank select instruction changes the bank; it holds otherwise
// - selected bank is a 2-bit field of the status word
// - accesses to FF00H..FFFFH go to peripheral registers, not RAM
// - peripheral access by bit, byte or word, only widths each register allows
// - each peripheral register is read-write, read-only or write-only
// - every peripheral register loads its defined value on reset
// - timer counter and both capture/compare registers: word only, reset 0000H
// - conversion result at FF08H is read-only, word only
// - receive buffer read-only, transmit buffer read-write, byte only, reset FFH
// - port mode registers bit/byte, reset FFH; port data registers reset 00H
package brf_pkg;

    localparam logic [15:0] BRF_GPR_BASE = 16'hFEE0;
    localparam logic [15:0] BRF_GPR_LAST = 16'hFEFF;
    localparam logic [15:0] BRF_BANK0_BASE = 16'hFEF8;
    localparam logic [15:0] BRF_BANK1_BASE = 16'hFEF0;
    localparam logic [15:0] BRF_BANK2_BASE = 16'hFEE8;
    localparam logic [15:0] BRF_SFR_BASE = 16'hFF00;
    localparam logic [15:0] BRF_ADDR_CONV = 16'hFF08;
    localparam logic [15:0] BRF_ADDR_RXB = 16'hFF0A;
    localparam int BRF_GPR_BYTES = 32;

    // access widths
    localparam logic [1:0] BRF_WIDTH_BIT = 2'h0;
    localparam logic [1:0] BRF_WIDTH_BYTE = 2'h1;
    localparam logic [1:0] BRF_WIDTH_WORD = 2'h2;

    // reset values
    localparam logic [1:0] BRF_RST_BANK = 2'h0;
    localparam logic [7:0] BRF_RST_GPR = 8'h00;
    localparam logic [7:0] BRF_RST_PORT = 8'h00;
    localparam logic [7:0] BRF_RST_MODE = 8'hFF;
    localparam logic [7:0] BRF_RST_SERIAL = 8'hFF;
    localparam logic [7:0] BRF_RST_WIDE = 8'h00;
    localparam logic [7:0] BRF_RST_UNDEF = 8'h00;

    typedef struct packed {
        logic [7:0] addr;
        logic rd;
        logic wr;
        logic bitOk;
        logic byteOk;
        logic wordOk;
        logic [7:0] rst;
    } brf_sfr_attr_type;

    localparam int BRF_SLOTS = 24;
    localparam int BRF_SLOT_W = 5;
    localparam logic [4:0] BRF_SLOT_P0 = 5'h00;
    localparam logic [4:0] BRF_SLOT_P2 = 5'h02;
    localparam logic [4:0] BRF_SLOT_CONV = 5'h06;
    localparam logic [4:0] BRF_SLOT_RXB = 5'h08;
    localparam logic [4:0] BRF_SLOT_TXB = 5'h09;
    localparam logic [4:0] BRF_SLOT_TIMER = 5'h0C;
    localparam logic [4:0] BRF_SLOT_CRA = 5'h0E;
    localparam logic [4:0] BRF_SLOT_CRB = 5'h10;
    localparam logic [4:0] BRF_SLOT_DIR0 = 5'h12;

    // general registers accept every width; word needs even address
    localparam brf_sfr_attr_type BRF_GPR_ATTR = '{8'h00, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, BRF_RST_GPR};

    // fields: low address, rd, wr, bit, byte, word, reset; word registers use two adjacent slots
    localparam brf_sfr_attr_type BRF_SFR_TABLE [BRF_SLOTS] = '{
        '{8'h00, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, BRF_RST_PORT},
        '{8'h01, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, BRF_RST_PORT},
        '{8'h02, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, BRF_RST_UNDEF},
        '{8'h03, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, BRF_RST_PORT},
        '{8'h06, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, BRF_RST_PORT},
        '{8'h07, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, BRF_RST_PORT},
        '{8'h08, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, BRF_RST_UNDEF},
        '{8'h09, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, BRF_RST_UNDEF},
        '{8'h0A, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, BRF_RST_SERIAL},
        '{8'h0B, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, BRF_RST_SERIAL},
        '{8'h0C, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, BRF_RST_PORT},
        '{8'h0D, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, BRF_RST_PORT},
        '{8'h10, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, BRF_RST_WIDE},
        '{8'h11, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, BRF_RST_WIDE},
        '{8'h12, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, BRF_RST_WIDE},
        '{8'h13, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, BRF_RST_WIDE},
        '{8'h14, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, BRF_RST_WIDE},
        '{8'h15, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, BRF_RST_WIDE},
        '{8'h20, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, BRF_RST_MODE},
        '{8'h21, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, BRF_RST_MODE},
        '{8'h23, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, BRF_RST_MODE},
        '{8'h26, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, BRF_RST_MODE},
        '{8'h27, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, BRF_RST_MODE},
        '{8'h2C, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, BRF_RST_MODE}
    };

endpackage

// ==== hw/brf_regfile.sv ====
// banked general register file with peripheral register storage behind one data port
`timescale 1ns/10ps
`default_nettype none
module brf_regfile
    import brf_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // bank select from the execution core
    input wire logic bankSelStrobe,
    input wire logic [1:0] bankSelValue,
    output logic [1:0] pswBankField,
    // register access by name in the current bank
    input wire logic [2:0] regIdx,
    input wire logic regPair,
    input wire logic regWrEn,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    // data memory access
    input wire logic memReq,
    input wire logic memWrite,
    input wire logic [1:0] memWidth,
    input wire logic [15:0] memAddr,
    input wire logic [2:0] memBitIdx,
    input wire logic [15:0] memWrData,
    output logic memAck,
    output logic memErr,
    output logic [15:0] memRdData,
    output logic memRamSel,
    // peripheral side
    input wire logic [7:0] portTwoPin,
    input wire logic [15:0] convResultIn,
    input wire logic convResultLoad,
    input wire logic [7:0] rxDataIn,
    input wire logic rxDataLoad,
    input wire logic [15:0] timerCountIn,
    output logic [7:0] portDataZero,
    output logic [7:0] portDirZero,
    output logic [7:0] serialTxData,
    output logic serialTxLoad,
    output logic [15:0] captureCompareA,
    output logic [15:0] captureCompareB
);

    logic [7:0] gpr [BRF_GPR_BYTES];
    logic [7:0] sfrByte [BRF_SLOTS];
    logic [7:0] portTwoSync1;
    logic [7:0] portTwoSync2;
    logic decGprHit;
    logic decSfrSpace;
    logic decSfrHit;
    logic [BRF_SLOT_W-1:0] decSlot;
    logic [BRF_SLOT_W-1:0] slotHi;
    logic decOk;
    logic [4:0] memOff;
    logic [4:0] memOffHi;
    logic [4:0] byteIdx;
    logic [4:0] pairLo;
    logic [4:0] pairHi;
    logic gprMemWrite;
    logic sfrWrite;
    logic [15:0] next_rdData;

    brf_sfr_decode u_decode (
        .addr(memAddr),
        .width(memWidth),
        .isWrite(memWrite),
        .gprHit(decGprHit),
        .sfrSpace(decSfrSpace),
        .sfrHit(decSfrHit),
        .slot(decSlot),
        .accessOk(decOk)
    );

    function automatic logic [15:0] readSel(input logic [7:0] lo, input logic [7:0] hi,
                                            input logic [1:0] w, input logic [2:0] b);
        case (w)
            BRF_WIDTH_BIT: readSel = {15'h0000, lo[b]};
            BRF_WIDTH_BYTE: readSel = {8'h00, lo};
            default: readSel = {hi, lo};
        endcase
    endfunction

    // bank b sits at base FEE0H + (3-b)*8, i.e. offset {~b, reg}
    assign byteIdx = {~pswBankField, regIdx};
    assign pairLo = {~pswBankField, regIdx[1:0], 1'b0};
    assign pairHi = {~pswBankField, regIdx[1:0], 1'b1};
    assign memOff = memAddr[4:0];
    assign memOffHi = {memAddr[4:1], 1'b1};
    assign slotHi = decSlot + BRF_SLOT_W'(1);
    assign gprMemWrite = memReq && memWrite && decGprHit && decOk;
    assign sfrWrite = memReq && memWrite && decSfrHit && decOk;
    // anything outside both regions belongs to plain RAM
    assign memRamSel = memReq && !decGprHit && !decSfrSpace;

    // only a bank select instruction moves the field
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            pswBankField <= BRF_RST_BANK;
        else if (bankSelStrobe)
            pswBankField <= bankSelValue;
    end

    // named write wins over a same-cycle memory write; the core never issues both
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < BRF_GPR_BYTES; i++)
                gpr[i] <= BRF_RST_GPR;
        end
        else if (regWrEn)
        begin
            if (regPair)
            begin
                gpr[pairLo] <= regWrData[7:0];
                gpr[pairHi] <= regWrData[15:8];
            end
            else
                gpr[byteIdx] <= regWrData[7:0];
        end
        else if (gprMemWrite)
        begin
            case (memWidth)
                BRF_WIDTH_BIT: gpr[memOff][memBitIdx] <= memWrData[0];
                BRF_WIDTH_BYTE: gpr[memOff] <= memWrData[7:0];
                default:
                begin
                    gpr[memOff] <= memWrData[7:0];
                    gpr[memOffHi] <= memWrData[15:8];
                end
            endcase
        end
    end

    // pin input crosses into the clock domain before anyone reads it
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            portTwoSync1 <= BRF_RST_UNDEF;
            portTwoSync2 <= BRF_RST_UNDEF;
        end
        else
        begin
            portTwoSync1 <= portTwoPin;
            portTwoSync2 <= portTwoSync1;
        end
    end

    // read-only slots follow their peripheral; writable slots follow the core
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < BRF_SLOTS; i++)
                sfrByte[i] <= BRF_SFR_TABLE[i].rst;
        end
        else
        begin
            sfrByte[BRF_SLOT_P2] <= portTwoSync2;
            sfrByte[BRF_SLOT_TIMER] <= timerCountIn[7:0];
            sfrByte[BRF_SLOT_TIMER + 5'h01] <= timerCountIn[15:8];
            if (convResultLoad)
            begin
                sfrByte[BRF_SLOT_CONV] <= convResultIn[7:0];
                sfrByte[BRF_SLOT_CONV + 5'h01] <= convResultIn[15:8];
            end
            if (rxDataLoad)
                sfrByte[BRF_SLOT_RXB] <= rxDataIn;
            if (sfrWrite)
            begin
                case (memWidth)
                    BRF_WIDTH_BIT: sfrByte[decSlot][memBitIdx] <= memWrData[0];
                    BRF_WIDTH_BYTE: sfrByte[decSlot] <= memWrData[7:0];
                    default:
                    begin
                        sfrByte[decSlot] <= memWrData[7:0];
                        sfrByte[slotHi] <= memWrData[15:8];
                    end
                endcase
            end
        end
    end

    always_comb
    begin
        next_rdData = '0;
        if (decGprHit)
            next_rdData = readSel(gpr[memOff], gpr[memOffHi], memWidth, memBitIdx);
        else if (decSfrHit)
            next_rdData = readSel(sfrByte[decSlot], sfrByte[slotHi], memWidth, memBitIdx);
    end

    // one-cycle answer; a refused access reports an error and changes nothing
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            memAck <= 1'b0;
            memErr <= 1'b0;
            memRdData <= '0;
            serialTxLoad <= 1'b0;
        end
        else
        begin
            memAck <= memReq && (decGprHit || decSfrSpace) && decOk;
            memErr <= memReq && (decGprHit || decSfrSpace) && !decOk;
            serialTxLoad <= sfrWrite && (decSlot == BRF_SLOT_TXB);
            if (memReq && !memWrite && decOk)
                memRdData <= next_rdData;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            regRdData <= '0;
        else if (regPair)
            regRdData <= {gpr[pairHi], gpr[pairLo]};
        else
            regRdData <= {8'h00, gpr[byteIdx]};
    end

    assign portDataZero = sfrByte[BRF_SLOT_P0];
    assign portDirZero = sfrByte[BRF_SLOT_DIR0];
    assign serialTxData = sfrByte[BRF_SLOT_TXB];
    assign captureCompareA = {sfrByte[BRF_SLOT_CRA + 5'h01], sfrByte[BRF_SLOT_CRA]};
    assign captureCompareB = {sfrByte[BRF_SLOT_CRB + 5'h01], sfrByte[BRF_SLOT_CRB]};

    // checks
    logic afterReset;
    logic [4:0] chkIdx;
    logic [4:0] chkLo;
    logic [4:0] chkHi;
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            afterReset <= 1'b0;
        else
            afterReset <= 1'b1;
    end
    assign chkIdx = byteIdx;
    assign chkLo = pairLo;
    assign chkHi = pairHi;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    property p_gpr_range;
        memReq && !memWrite && memWidth == BRF_WIDTH_BYTE && memAddr >= BRF_GPR_BASE
        && memAddr <= BRF_GPR_LAST |=> memAck && !memErr;
    endproperty
    a_gpr_range: assert property (p_gpr_range) else $error("gpr byte read not answered");

    property p_bank_map;
        regWrEn && !regPair |=> gpr[$past(chkIdx)] == $past(regWrData[7:0]);
    endproperty
    a_bank_map: assert property (p_bank_map) else $error("bank byte write misplaced");

    property p_pair;
        regWrEn && regPair |=> {gpr[$past(chkHi)], gpr[$past(chkLo)]} == $past(regWrData);
    endproperty
    a_pair: assert property (p_pair) else $error("pair write misplaced");

    property p_bank_hold;
        !bankSelStrobe |=> $stable(pswBankField);
    endproperty
    a_bank_hold: assert property (p_bank_hold) else $error("bank moved without select");

    property p_bank_take;
        bankSelStrobe ##1 !bankSelStrobe |-> pswBankField == $past(bankSelValue) ##1
        pswBankField == $past(bankSelValue, 2);
    endproperty
    a_bank_take: assert property (p_bank_take) else $error("bank select not held");

    property p_sfr_range;
        memReq && memAddr[15:8] == BRF_SFR_BASE[15:8] |-> !memRamSel;
    endproperty
    a_sfr_range: assert property (p_sfr_range) else $error("peripheral address sent to RAM");

    property p_width;
        memReq && memWidth == BRF_WIDTH_WORD && memAddr == BRF_ADDR_RXB |=> memErr && !memAck;
    endproperty
    a_width: assert property (p_width) else $error("disallowed width accepted");

    property p_readonly;
        memReq && memWrite && memAddr == BRF_ADDR_RXB |=> memErr ##0 !serialTxLoad;
    endproperty
    a_readonly: assert property (p_readonly) else $error("write to read-only accepted");

    property p_reset_vals;
        !afterReset |-> portDataZero == BRF_RST_PORT && portDirZero == BRF_RST_MODE;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("port reset value wrong");

    property p_wide_reset;
        !afterReset |-> captureCompareA == {BRF_RST_WIDE, BRF_RST_WIDE}
        && captureCompareB == {BRF_RST_WIDE, BRF_RST_WIDE};
    endproperty
    a_wide_reset: assert property (p_wide_reset) else $error("wide reset value wrong");

    property p_serial_reset;
        !afterReset |-> serialTxData == BRF_RST_SERIAL;
    endproperty
    a_serial_reset: assert property (p_serial_reset) else $error("tx buffer reset wrong");

    property p_conv;
        convResultLoad ##1 (memReq && !memWrite && memWidth == BRF_WIDTH_WORD
        && memAddr == BRF_ADDR_CONV && !convResultLoad) |=> memAck
        && memRdData == $past(convResultIn, 2);
    endproperty
    a_conv: assert property (p_conv) else $error("conversion result read wrong");

    property p_no_change;
        memReq && memWrite && !decOk |=> $stable(captureCompareA) && $stable(captureCompareB)
        && $stable(serialTxData) && $stable(portDirZero) && !serialTxLoad;
    endproperty
    a_no_change: assert property (p_no_change) else $error("refused write changed state");

    property p_cov_bank;
        bankSelStrobe && bankSelValue != pswBankField;
    endproperty
    c_cov_bank: cover property (p_cov_bank);

    property p_cov_word;
        memReq && memWidth == BRF_WIDTH_WORD && decSfrHit ##1 memAck;
    endproperty
    c_cov_word: cover property (p_cov_word);

    property p_cov_err;
        memErr;
    endproperty
    c_cov_err: cover property (p_cov_err);

endmodule
`default_nettype wire

// ==== hw/brf_sfr_decode.sv ====
// address decode for general registers and peripheral register slots
`timescale 1ns/10ps
`default_nettype none
module brf_sfr_decode
    import brf_pkg::*;
(
    // access under decode
    input wire logic [15:0] addr,
    input wire logic [1:0] width,
    input wire logic isWrite,
    // decode result
    output logic gprHit,
    output logic sfrSpace,
    output logic sfrHit,
    output logic [BRF_SLOT_W-1:0] slot,
    output logic accessOk
);

    logic [BRF_SLOTS-1:0] match;
    brf_sfr_attr_type attr;

    function automatic logic widthAllowed(input brf_sfr_attr_type a, input logic [1:0] w,
                                          input logic even);
        case (w)
            BRF_WIDTH_BIT: widthAllowed = a.bitOk;
            BRF_WIDTH_BYTE: widthAllowed = a.byteOk;
            BRF_WIDTH_WORD: widthAllowed = a.wordOk && even;
            default: widthAllowed = 1'b0;
        endcase
    endfunction

    assign gprHit = (addr[15:5] == BRF_GPR_BASE[15:5]);
    assign sfrSpace = (addr[15:8] == BRF_SFR_BASE[15:8]);

    genvar g;
    generate
        for (g = 0; g < BRF_SLOTS; g++)
        begin : gen_match
            assign match[g] = sfrSpace && (addr[7:0] == BRF_SFR_TABLE[g].addr);
        end
    endgenerate

    always_comb
    begin
        slot = '0;
        sfrHit = 1'b0;
        for (int i = 0; i < BRF_SLOTS; i++)
        begin
            if (match[i])
            begin
                slot = BRF_SLOT_W'(i);
                sfrHit = 1'b1;
            end
        end
    end

    assign attr = BRF_SFR_TABLE[slot];

    // refusal covers wrong width, odd word address, and direction not allowed
    always_comb
    begin
        if (gprHit)
            accessOk = widthAllowed(BRF_GPR_ATTR, width, !addr[0]);
        else
            accessOk = sfrHit && widthAllowed(attr, width, !addr[0])
                       && (isWrite ? attr.wr : attr.rd);
    end

endmodule
`default_nettype wire
